// *** design/toc_defines.svh ***
// Register offsets, field positions and reset values
`ifndef TOC_DEFINES_SVH
`define TOC_DEFINES_SVH

// ==========================================================
// Register indices (byte address = index * 4)
`define TOC_IDX_FORCE      8'h81
`define TOC_IDX_C7DATA     8'h83
`define TOC_IDX_SELECT     8'h80
`define TOC_IDX_C7MASK     8'h82
`define TOC_IDX_COUNT      8'h84
`define TOC_IDX_CTRL       8'h86
`define TOC_IDX_ACT_HI     8'h88
`define TOC_IDX_ACT_LO     8'h89
`define TOC_IDX_STATUS     8'h8e
`define TOC_IDX_IMASK      8'h8c
`define TOC_IDX_PDATA      8'hae
`define TOC_IDX_PDIR       8'haf
`define TOC_IDX_CMP_BASE   8'h90
`define TOC_IDX_CMP_LAST   8'h97

// ==========================================================
// Control register fields
`define TOC_CTRL_EN_BIT    7
`define TOC_CTRL_CRE_BIT   3
`define TOC_CTRL_PR_LSB    0
`define TOC_PR_MAX         3'h5

// ==========================================================
// Reset values
`define TOC_RST_BYTE       8'h00
`define TOC_RST_WORD       16'h0000
`define TOC_RST_DWORD      32'h0000_0000
`define TOC_RST_PRE        5'h00
`define TOC_RST_BIT        1'b0
`define TOC_CH7            3'h7

`endif

// *** design/toc_pkg.sv ***
// Types shared by the output-compare control block
package toc_pkg;
  typedef logic [7:0]  toc_byte_t;
  typedef logic [15:0] toc_word_t;
endpackage

// *** design/toc_timer.sv ***
// Output-compare control of a 16-bit eight-channel timer with APB registers
`timescale 1ns/100ps
`default_nettype none
`include "toc_defines.svh"

module toc_timer
  import toc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  port_in,
  output logic      [7:0]  port_out,
  output logic      [7:0]  port_oe,
  output logic             irq
);

  // ==========================================================
  // Register state
  toc_byte_t select_r, select_nxt;
  toc_byte_t c7mask_r, c7mask_nxt;
  toc_byte_t c7data_r, c7data_nxt;
  toc_byte_t ctrl_r, ctrl_nxt;
  toc_byte_t acthi_r, acthi_nxt;
  toc_byte_t actlo_r, actlo_nxt;
  toc_byte_t status_r, status_nxt;
  toc_byte_t imask_r, imask_nxt;
  toc_byte_t pdata_r, pdata_nxt;
  toc_byte_t pdir_r, pdir_nxt;
  toc_byte_t ocl_r, ocl_nxt;
  toc_word_t count_r, count_nxt;
  logic [4:0] pre_r, pre_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  toc_byte_t oe_r, oe_nxt;
  toc_byte_t pout_r, pout_nxt;
  logic      irq_r, irq_nxt;
  toc_word_t cmp_r [0:7];
  toc_word_t cmp_nxt [0:7];

  logic       wr_en;
  logic       rd_en;
  logic [9:0] idx;
  logic       tick;
  logic       cmp_sel;
  logic [2:0] cmp_ch;
  toc_byte_t  match;
  toc_byte_t  force_v;
  toc_byte_t  act;
  logic [15:0] act_fld;
  logic [15:0] act_fld_nxt;

  assign pready  = 1'b1;
  assign idx     = paddr[11:2];
  assign wr_en   = psel & penable & pwrite;
  // Read address is decoded in setup so the access-phase data is a flop
  assign rd_en   = psel & ~penable & ~pwrite;
  assign cmp_sel = (idx >= {2'b00, `TOC_IDX_CMP_BASE}) &&
                   (idx <= {2'b00, `TOC_IDX_CMP_LAST});
  assign cmp_ch  = idx[2:0];
  assign act_fld = {acthi_r, actlo_r};
  assign act_fld_nxt = {acthi_nxt, actlo_nxt};

  function automatic logic is_reg(input logic [9:0] i, input logic [7:0] r);
    is_reg = (i == {2'b00, r});
  endfunction

  // Two-bit action code of one channel from the packed action field
  function automatic logic [1:0] act_code(input logic [15:0] f,
                                          input int          ch);
    act_code = f[2*ch +: 2];
  endfunction

  // ==========================================================
  // Prescaler: divides by 2^n, ticks and wraps when all masked stages are ones
  logic [4:0] pre_mask;
  always_comb begin
    pre_mask = 5'h00;
    unique case (ctrl_r[`TOC_CTRL_PR_LSB +: 3])
      3'h0: pre_mask = 5'h00;
      3'h1: pre_mask = 5'h01;
      3'h2: pre_mask = 5'h03;
      3'h3: pre_mask = 5'h07;
      3'h4: pre_mask = 5'h0f;
      default: pre_mask = 5'h1f;
    endcase
  end

  assign tick = ctrl_r[`TOC_CTRL_EN_BIT] && ((pre_r & pre_mask) == pre_mask);

  // ==========================================================
  // Compare and force events
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // match on equal count, compare role only
      match[i] = tick && select_r[i] && (count_r == cmp_r[i]);
    end
  end

  // force bits act at the write itself
  assign force_v = (wr_en && is_reg(idx, `TOC_IDX_FORCE)) ?
                   (pwdata[7:0] & select_r) : `TOC_RST_BYTE;
  assign act     = match | force_v;

  // ==========================================================
  // Compare output lines
  always_comb begin
    ocl_nxt = ocl_r;
    for (int i = 0; i < 8; i++) begin
      if (act[i]) begin
        unique case (act_code(act_fld, i))
          2'b00: ocl_nxt[i] = ocl_r[i];
          2'b01: ocl_nxt[i] = ~ocl_r[i];
          2'b10: ocl_nxt[i] = 1'b0;
          2'b11: ocl_nxt[i] = 1'b1;
        endcase
      end
      // channel-7 copies data, and wins over others
      if (act[`TOC_CH7] && c7mask_r[i]) begin
        ocl_nxt[i] = c7data_r[i];
      end
    end
  end

  // ==========================================================
  // Pin ownership, worked from the next register state so that the pin
  // flops change at the same edge as the registers behind them
  always_comb begin
    oe_nxt   = `TOC_RST_BYTE;
    pout_nxt = `TOC_RST_BYTE;
    for (int i = 0; i < 8; i++) begin
      // nonzero action or mask forces output
      if (select_nxt[i] && ((act_code(act_fld_nxt, i) != 2'b00) ||
                            c7mask_nxt[i])) begin
        oe_nxt[i]   = 1'b1;
        pout_nxt[i] = ocl_nxt[i];
      end else begin
        // plain I/O, latched data driven when free
        oe_nxt[i]   = pdir_nxt[i];
        pout_nxt[i] = pdata_nxt[i];
      end
    end
  end

  assign irq_nxt  = |(status_nxt & imask_nxt);
  assign port_oe  = oe_r;
  assign port_out = pout_r;
  assign irq      = irq_r;

  // ==========================================================
  // Register writes and counter
  always_comb begin
    select_nxt = select_r;
    c7mask_nxt = c7mask_r;
    c7data_nxt = c7data_r;
    ctrl_nxt   = ctrl_r;
    acthi_nxt  = acthi_r;
    actlo_nxt  = actlo_r;
    imask_nxt  = imask_r;
    pdata_nxt  = pdata_r;
    pdir_nxt   = pdir_r;
    status_nxt = status_r;
    count_nxt  = count_r;
    pre_nxt    = ctrl_r[`TOC_CTRL_EN_BIT] ? ((pre_r + 5'h01) & pre_mask)
                                          : pre_r;
    for (int i = 0; i < 8; i++) begin
      cmp_nxt[i] = cmp_r[i];
    end
    if (tick) begin
      if (match[`TOC_CH7] && ctrl_r[`TOC_CTRL_CRE_BIT]) begin
        count_nxt = `TOC_RST_WORD;
      end else begin
        count_nxt = count_r + 16'h0001;
      end
    end
    if (wr_en) begin
      if (is_reg(idx, `TOC_IDX_SELECT))  select_nxt = pwdata[7:0];
      // mask write can move port_oe bits of selected channels
      if (is_reg(idx, `TOC_IDX_C7MASK))  c7mask_nxt = pwdata[7:0];
      if (is_reg(idx, `TOC_IDX_C7DATA))  c7data_nxt = pwdata[7:0];
      if (is_reg(idx, `TOC_IDX_CTRL))    ctrl_nxt   = pwdata[7:0];
      if (is_reg(idx, `TOC_IDX_ACT_HI))  acthi_nxt  = pwdata[7:0];
      if (is_reg(idx, `TOC_IDX_ACT_LO))  actlo_nxt  = pwdata[7:0];
      if (is_reg(idx, `TOC_IDX_IMASK))   imask_nxt  = pwdata[7:0];
      // always stored, reaches pin only when free
      if (is_reg(idx, `TOC_IDX_PDATA))   pdata_nxt  = pwdata[7:0];
      if (is_reg(idx, `TOC_IDX_PDIR))    pdir_nxt   = pwdata[7:0];
      if (is_reg(idx, `TOC_IDX_STATUS))  status_nxt = status_r & ~pwdata[7:0];
      if (cmp_sel)                       cmp_nxt[cmp_ch] = pwdata[15:0];
    end
    // only real matches set flags; set wins over clear
    status_nxt = status_nxt | match;
  end

  // ==========================================================
  // Read mux
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (rd_en) begin
      if (is_reg(idx, `TOC_IDX_SELECT)) prdata_nxt[7:0] = select_r;
      if (is_reg(idx, `TOC_IDX_C7MASK)) prdata_nxt[7:0] = c7mask_r;
      if (is_reg(idx, `TOC_IDX_C7DATA)) prdata_nxt[7:0] = c7data_r;
      if (is_reg(idx, `TOC_IDX_CTRL))   prdata_nxt[7:0] = ctrl_r;
      if (is_reg(idx, `TOC_IDX_ACT_HI)) prdata_nxt[7:0] = acthi_r;
      if (is_reg(idx, `TOC_IDX_ACT_LO)) prdata_nxt[7:0] = actlo_r;
      if (is_reg(idx, `TOC_IDX_IMASK))  prdata_nxt[7:0] = imask_r;
      if (is_reg(idx, `TOC_IDX_STATUS)) prdata_nxt[7:0] = status_r;
      if (is_reg(idx, `TOC_IDX_PDIR))   prdata_nxt[7:0] = pdir_r;
      // Output pins read the latch, input pins read the pin
      if (is_reg(idx, `TOC_IDX_PDATA))
        prdata_nxt[7:0] = (pdata_r & port_oe) | (port_in & ~port_oe);
      if (is_reg(idx, `TOC_IDX_COUNT))  prdata_nxt[15:0] = count_r;
      if (cmp_sel)                      prdata_nxt[15:0] = cmp_r[cmp_ch];
      // force register reads zero, falls to default
    end
  end

  // Read data is loaded at the setup edge and stands through the access
  // phase; a count read shows the value one clock before the access
  assign prdata  = prdata_r;
  assign pslverr = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_r <= `TOC_RST_BYTE;
      c7mask_r <= `TOC_RST_BYTE;
      c7data_r <= `TOC_RST_BYTE;
      ctrl_r   <= `TOC_RST_BYTE;
      acthi_r  <= `TOC_RST_BYTE;
      actlo_r  <= `TOC_RST_BYTE;
      status_r <= `TOC_RST_BYTE;
      imask_r  <= `TOC_RST_BYTE;
      pdata_r  <= `TOC_RST_BYTE;
      pdir_r   <= `TOC_RST_BYTE;
      ocl_r    <= `TOC_RST_BYTE;
      count_r  <= `TOC_RST_WORD;
      pre_r    <= `TOC_RST_PRE;
      for (int i = 0; i < 8; i++) begin
        cmp_r[i] <= `TOC_RST_WORD;
      end
    end else begin
      select_r <= select_nxt;
      c7mask_r <= c7mask_nxt;
      c7data_r <= c7data_nxt;
      ctrl_r   <= ctrl_nxt;
      acthi_r  <= acthi_nxt;
      actlo_r  <= actlo_nxt;
      status_r <= status_nxt;
      imask_r  <= imask_nxt;
      pdata_r  <= pdata_nxt;
      pdir_r   <= pdir_nxt;
      ocl_r    <= ocl_nxt;
      count_r  <= count_nxt;
      pre_r    <= pre_nxt;
      for (int i = 0; i < 8; i++) begin
        cmp_r[i] <= cmp_nxt[i];
      end
    end
  end

  // ==========================================================
  // Output flops: pins, interrupt and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_r     <= `TOC_RST_BYTE;
      pout_r   <= `TOC_RST_BYTE;
      irq_r    <= `TOC_RST_BIT;
      prdata_r <= `TOC_RST_DWORD;
    end else begin
      oe_r     <= oe_nxt;
      pout_r   <= pout_nxt;
      irq_r    <= irq_nxt;
      prdata_r <= prdata_nxt;
    end
  end

endmodule // toc_timer
`default_nettype wire

// *** bench/toc_pin_load.sv ***
// Pin loads of the timer port, pulled up when undriven
`timescale 1ns/100ps
`default_nettype none
module toc_pin_load (
  input  wire logic [7:0] port_out,
  input  wire logic [7:0] port_oe,
  output logic      [7:0] port_in
);
  // Released pins read the pull-up, never the last driven level
  assign port_in = (port_out & port_oe) | ~port_oe;
endmodule // toc_pin_load
`default_nettype wire

// *** bench/toc_timer_properties.sv ***
// Port assertions for the output-compare timer
`timescale 1ns/100ps
`default_nettype none
module toc_timer_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  port_oe,
  input wire logic        irq
);
  // ====================
  // Bus and pin relations
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wr  = acc && pwrite;

  chk_reset_quiet: assert property
    ($rose(presetn) |-> port_oe == 8'h00 && !irq) else $error("bad reset");
  chk_force_zero: assert property
    (acc && !pwrite && paddr == 12'h204 |-> prdata == 32'h0)
    else $error("force reads nonzero");
  chk_dir_by_write: assert property
    ($changed(port_oe) |-> $past(wr)) else $error("direction moved");
  chk_latch_keeps_dir: assert property
    (wr && paddr == 12'h2b8 |=> $stable(port_oe)) else $error("latch dir");
  chk_data7_keeps_dir: assert property
    (wr && paddr == 12'h20c |=> $stable(port_oe)) else $error("data7 dir");
  chk_force_keeps_dir: assert property
    (wr && paddr == 12'h204 |=> $stable(port_oe)) else $error("force dir");
  chk_zero_wait: assert property
    (acc |-> pready && !pslverr) else $error("access stalled");
  chk_idle_rdata: assert property
    (!acc |-> prdata == 32'h0) else $error("stray read data");

  cover property (wr && paddr == 12'h204);
  cover property (wr && paddr == 12'h208);
  cover property ($rose(irq));
endmodule // toc_timer_properties

bind toc_timer toc_timer_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .port_oe(port_oe), .irq(irq)
);
`default_nettype wire

// *** bench/timer_output_compare_control_bench.sv ***
// Self-checking bench for the output-compare timer
`timescale 1ns/100ps
`default_nettype none
module timer_output_compare_control_bench
  import toc_pkg::*;
();
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  toc_byte_t   port_in, port_out, port_oe;
  int          n_fail, checks, cyc;
  logic [15:0] t0;

  toc_timer u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_in(port_in),
    .port_out(port_out), .port_oe(port_oe), .irq(irq)
  );
  toc_pin_load u_load (
    .port_out(port_out), .port_oe(port_oe), .port_in(port_in)
  );

  // ====================
  // Tasks
  task automatic stop_test;
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input toc_byte_t a, input toc_byte_t e);
    checks++;
    if (a !== e) begin
      n_fail++;
      $display("mismatch %0t got %h want %h", $time, a, e);
    end
  endtask
  task automatic apb(input logic w, input toc_byte_t i, input logic [31:0] d);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= {2'h0, i, 2'h0};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input toc_byte_t i, input toc_byte_t e);
    apb(1'h0, i, 32'h0);
    chk(q[7:0], e);
  endtask

  // ====================
  // Clock, timeout and sequence
  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end
  // A hang ends in the same report as a normal run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int k = 0; k < 4; k++) rd(8'h80 + 8'(k), 8'h00);
    apb(1'h1, 8'h01, 32'hff);
    rd(8'h01, 8'h00);
    // Ch2 toggle, ch1 low, ch0 high
    apb(1'h1, 8'h89, 32'h1b);
    chk(port_oe, 8'h00);
    apb(1'h1, 8'h80, 32'h0f);
    chk(port_oe, 8'h07);
    apb(1'h1, 8'h81, 32'h0f);
    chk(port_out, 8'h05);
    rd(8'h81, 8'h00);
    rd(8'h8e, 8'h00);
    apb(1'h1, 8'h81, 32'h04);
    chk(port_out, 8'h01);
    apb(1'h1, 8'haf, 32'hff);
    apb(1'h1, 8'hae, 32'ha2);
    chk(port_out, 8'ha1);
    apb(1'h1, 8'h80, 32'h00);
    chk(port_out, 8'ha2);
    apb(1'h1, 8'haf, 32'h00);
    apb(1'h1, 8'h89, 32'h00);
    apb(1'h1, 8'h88, 32'h08);
    apb(1'h1, 8'h82, 32'h30);
    apb(1'h1, 8'h83, 32'h30);
    apb(1'h1, 8'h80, 32'hb0);
    chk(port_oe, 8'h30);
    rd(8'haf, 8'h00);
    // Ch5 drives low in the same force as ch7, whose data wins
    apb(1'h1, 8'h81, 32'ha0);
    chk(port_out & 8'h30, 8'h30);
    apb(1'h1, 8'h80, 32'h81);
    apb(1'h1, 8'h97, 32'h0100);
    apb(1'h1, 8'h90, 32'h0040);
    apb(1'h1, 8'h86, 32'h88);
    // Past one counter period, clear of the next ch0 match
    repeat (400) @(posedge pclk);
    chk(8'(irq), 8'h00);
    rd(8'h8e, 8'h81);
    apb(1'h0, 8'h84, 32'h0);
    chk(8'(q[15:0] > 16'h0100), 8'h00);
    apb(1'h1, 8'h8c, 32'h01);
    chk(8'(irq), 8'h01);
    apb(1'h1, 8'h8e, 32'h01);
    chk(8'(irq), 8'h00);
    // Prescale by two, free run: 32 clocks between reads give 16 counts
    apb(1'h1, 8'h86, 32'h81);
    apb(1'h0, 8'h84, 32'h0);
    t0 = q[15:0];
    repeat (29) @(posedge pclk);
    apb(1'h0, 8'h84, 32'h0);
    chk(8'(q[15:0] - t0), 8'h10);
    stop_test();
  end
endmodule // timer_output_compare_control_bench
`default_nettype wire
